// file: logic/kbd_consts.svh
`ifndef KBD_CONSTS_SVH
`define KBD_CONSTS_SVH

// Clock rate
`define CLK_HZ 100000000
`define CLK_MHZ 100

// Strobe length in microseconds
`define STROBE_MIN_US 10
`define STROBE_NOM_US 50
`define STROBE_MAX_US 100
`define STROBE_MIN_CYC (`STROBE_MIN_US * `CLK_MHZ)
`define STROBE_NOM_CYC (`STROBE_NOM_US * `CLK_MHZ)
`define STROBE_MAX_CYC (`STROBE_MAX_US * `CLK_MHZ)

// Quiet time between two strobes, microseconds
`define STROBE_GAP_US 1
`define STROBE_GAP_CYC (`STROBE_GAP_US * `CLK_MHZ)

// Repeat rate in strobes per second
`define REPEAT_PER_S 20
`define REPEAT_CYC (`CLK_HZ / `REPEAT_PER_S)

// Input matrix and code layout
`define CODE_LINES 13
`define CODE_BITS 7
`define FUNC_KEYS 8
`define MOD_KEYS 3
`define QUEUE_DEPTH 4
`define IDLE_CODE_N 7'h7F

`endif

// file: logic/kbd_pkg.sv
package kbd_pkg;
    typedef logic [6:0] key_code_t;
    typedef logic [12:0] code_lines_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_STROBE = 2'b10,
        ST_GAP = 2'b11
    } strobe_state_t;
endpackage

// file: logic/pair_if.sv
`timescale 1ns/1ns
interface pair_if;
    import kbd_pkg::*;
    code_lines_t lines; // Synchronised line activity, 1 = active
    key_code_t code; // Position code of the pair
    logic valid; // Lines form a populated pair
    logic repeat_line; // Pair uses line 1 or 2
    modport decoder (input lines, output code, valid, repeat_line);
    modport user (output lines, input code, valid, repeat_line);
endinterface

// file: logic/pair_decoder.sv
`timescale 1ns/1ns
module pair_decoder (
    pair_if.decoder pair // Line pattern in, code out
);
    import kbd_pkg::*;
    logic [3:0] lo; // Lower active line, 1-based
    logic [3:0] hi; // Higher active line, 1-based
    logic [3:0] count;
    logic hit;

    // Count active lines and find the two ends
    always_comb begin
        lo = 4'h0;
        hi = 4'h0;
        count = 4'h0;
        for (int i = 12; i >= 0; i--) begin
            if (pair.lines[i]) begin
                count = count + 4'h1;
                lo = 4'(i + 1);
                if (hi == 4'h0) begin
                    hi = 4'(i + 1);
                end
            end
        end
    end

    // Fixed pair to code map; codes are lookup ids, not key numbers
    always_comb begin
        hit = 1'b1;
        pair.code = 7'h00;
        case ({lo, hi})
            8'h12: pair.code = 7'h01;
            8'h27: pair.code = 7'h02;
            8'h28: pair.code = 7'h03;
            8'h29: pair.code = 7'h04;
            8'h2A: pair.code = 7'h05;
            8'h2B: pair.code = 7'h06;
            8'h2C: pair.code = 7'h07;
            8'h2D: pair.code = 7'h08;
            8'h34: pair.code = 7'h09;
            8'h13: pair.code = 7'h0A;
            8'h35: pair.code = 7'h0B;
            8'h36: pair.code = 7'h0C;
            8'h14: pair.code = 7'h0D;
            8'h15: pair.code = 7'h0E;
            8'h16: pair.code = 7'h0F;
            8'h17: pair.code = 7'h10;
            8'h37: pair.code = 7'h11;
            8'h38: pair.code = 7'h12;
            8'h39: pair.code = 7'h13;
            8'h3A: pair.code = 7'h14;
            8'h3B: pair.code = 7'h15;
            8'h3C: pair.code = 7'h16;
            8'h3D: pair.code = 7'h17;
            8'h45: pair.code = 7'h18;
            8'h46: pair.code = 7'h19;
            8'h47: pair.code = 7'h1A;
            8'h48: pair.code = 7'h1B;
            8'h49: pair.code = 7'h1C;
            8'h4A: pair.code = 7'h1D;
            8'h4B: pair.code = 7'h1E;
            8'h18: pair.code = 7'h1F;
            8'h4C: pair.code = 7'h20;
            8'h4D: pair.code = 7'h21;
            8'h56: pair.code = 7'h22;
            8'h57: pair.code = 7'h23;
            8'h58: pair.code = 7'h24;
            8'h59: pair.code = 7'h25;
            8'h5A: pair.code = 7'h26;
            8'h5B: pair.code = 7'h27;
            8'h5C: pair.code = 7'h28;
            8'h5D: pair.code = 7'h29;
            8'h19: pair.code = 7'h2A;
            8'h1A: pair.code = 7'h2B;
            8'h1B: pair.code = 7'h2C;
            8'h67: pair.code = 7'h2D;
            8'h1C: pair.code = 7'h2E;
            8'h68: pair.code = 7'h2F;
            8'h69: pair.code = 7'h30;
            8'h6A: pair.code = 7'h31;
            8'h6B: pair.code = 7'h32;
            8'h6C: pair.code = 7'h33;
            8'h6D: pair.code = 7'h34;
            8'h1D: pair.code = 7'h35;
            8'h78: pair.code = 7'h36;
            8'h79: pair.code = 7'h37;
            8'h23: pair.code = 7'h38;
            8'h24: pair.code = 7'h39;
            8'h7A: pair.code = 7'h3A;
            8'h7B: pair.code = 7'h3B;
            8'h7C: pair.code = 7'h3C;
            8'h7D: pair.code = 7'h3D;
            8'h89: pair.code = 7'h3E;
            8'h8A: pair.code = 7'h3F;
            8'h8B: pair.code = 7'h40;
            8'h8C: pair.code = 7'h41;
            8'h8D: pair.code = 7'h42;
            8'h9A: pair.code = 7'h43;
            8'h9B: pair.code = 7'h44;
            8'h9C: pair.code = 7'h45;
            8'h25: pair.code = 7'h46;
            8'h26: pair.code = 7'h47;
            8'h9D: pair.code = 7'h48;
            8'hAB: pair.code = 7'h49;
            8'hAD: pair.code = 7'h4A;
            8'hBD: pair.code = 7'h4B;
            8'hCD: pair.code = 7'h4C;
            8'hAC: pair.code = 7'h4D;
            8'hBC: pair.code = 7'h4E;
            default: hit = 1'b0;
        endcase
    end

    // Exactly two lines and a populated position
    assign pair.valid = hit && (count == 4'h2);
    assign pair.repeat_line = (lo == 4'h1) || (lo == 4'h2);
endmodule

// file: logic/keyboard_position_encoder.sv
// Notes on behaviour
// - A key shows as simultaneous pulses on exactly two of thirteen lines; one event.
// - Each valid line pair maps to a fixed 7-bit position code.
// - Keys are emitted in the order pressed so overlapping presses survive.
// - The code is latched onto the seven outputs before the strobe starts.
// - Strobe lasts 10 to 50 us, nominally 50 us.
// - Code outputs hold the last code until the next one replaces it.
// - Function keys bypass the encoder, each on its own output.
// - Function key output is low while held, high otherwise.
// - Codes are unique per position but not equal to the position number.
// - All outputs are high after reset and go low when active.
// - A held repeat key gives further strobes about twenty per second, only when the last key's pair is on line 1 or 2.
// - Control, shift and lock pass straight through unencoded.
`timescale 1ns/1ns
`include "kbd_consts.svh"
module keyboard_position_encoder #(
    parameter int STROBE_NOM = `STROBE_NOM_CYC, // Strobe length, cycles
    parameter int STROBE_MIN = `STROBE_MIN_CYC, // Shortened strobe under rollover
    parameter int STROBE_GAP = `STROBE_GAP_CYC, // Quiet time between strobes
    parameter int REPEAT_PERIOD = `REPEAT_CYC, // Repeat interval, cycles
    parameter int FUNC_W = `FUNC_KEYS, // Number of function keys
    parameter int DEPTH = `QUEUE_DEPTH // Pending key events held in order
) (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire kbd_pkg::code_lines_t code_line_n, // Keyswitch pulses, active low
    input wire logic repeat_hold, // Repeat key still held, active high
    input wire logic [FUNC_W-1:0] func_key_n, // Function keys, low when down
    input wire logic [`MOD_KEYS-1:0] mod_key_n, // Control, shift, lock, low when down
    output logic [`CODE_BITS-1:0] code_n, // Position code, inverted
    output logic key_valid_pulse_n, // Strobe, low while active
    output logic [FUNC_W-1:0] func_out_n, // Function key levels
    output logic [`MOD_KEYS-1:0] mod_out_n // Modifier key levels
);
    import kbd_pkg::*;

    localparam int TW = $clog2(REPEAT_PERIOD + 1);
    localparam int AW = $clog2(DEPTH);

    // Input synchronisers; first stage read only by the second
    code_lines_t line_meta;
    code_lines_t line_sync;
    logic rep_meta;
    logic rep_sync;
    logic [FUNC_W-1:0] func_meta;
    logic [FUNC_W-1:0] func_sync;
    logic [`MOD_KEYS-1:0] mod_meta;
    logic [`MOD_KEYS-1:0] mod_sync;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            line_meta <= 13'h0000;
            line_sync <= 13'h0000;
            rep_meta <= 1'b0;
            rep_sync <= 1'b0;
            func_meta <= '0;
            func_sync <= '0;
            mod_meta <= '0;
            mod_sync <= '0;
        end else begin
            line_meta <= ~code_line_n;
            line_sync <= line_meta;
            rep_meta <= repeat_hold;
            rep_sync <= rep_meta;
            func_meta <= ~func_key_n;
            func_sync <= func_meta;
            mod_meta <= ~mod_key_n;
            mod_sync <= mod_meta;
        end
    end

    // Pair decode
    pair_if pair ();
    assign pair.lines = line_sync;

    pair_decoder decode (
        .pair(pair.decoder)
    );

    // Event detection: a new pattern that forms a valid pair
    code_lines_t prev_lines;
    logic new_key;
    assign new_key = pair.valid && (line_sync != prev_lines);

    // Ordered queue of pending codes, with the repeat flag alongside
    logic [`CODE_BITS:0] queue [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic q_empty;
    logic q_full;
    logic pop;

    assign q_empty = (wr_ptr == rd_ptr);
    assign q_full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

    // Pointer arithmetic; a press with the queue full is dropped, which a
    // human typist cannot reach given the strobe rate
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (new_key && !q_full) begin
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            prev_lines <= 13'h0000;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            prev_lines <= line_sync;
        end
    end

    // Queue storage needs no reset; only written slots are ever read
    always_ff @(posedge sys_clk) begin
        if (new_key && !q_full) begin
            queue[wr_ptr[AW-1:0]] <= {pair.repeat_line, pair.code};
        end
    end

    // Strobe sequencer
    strobe_state_t state;
    strobe_state_t next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    key_code_t code;
    key_code_t next_code;
    logic code_rep;
    logic next_code_rep;
    logic strobe;
    logic next_strobe;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_code = code;
        next_code_rep = code_rep;
        next_strobe = 1'b0;
        pop = 1'b0;
        case (state)
            ST_IDLE: begin
                if (!q_empty) begin
                    pop = 1'b1;
                    next_code = queue[rd_ptr[AW-1:0]][`CODE_BITS-1:0];
                    next_code_rep = queue[rd_ptr[AW-1:0]][`CODE_BITS];
                    next_timer = '0;
                    next_state = ST_SETUP;
                end else if (code_rep && rep_sync) begin
                    // Repeat interval counted from the end of the gap after the last strobe
                    if (timer >= TW'(REPEAT_PERIOD - 1)) begin
                        next_timer = '0;
                        next_state = ST_SETUP;
                    end else begin
                        next_timer = timer + 1'b1;
                    end
                end else begin
                    next_timer = '0;
                end
            end
            ST_SETUP: begin
                // Code already on the pins for one cycle before the strobe
                next_strobe = 1'b1;
                next_timer = '0;
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                // Cut short to the minimum when more keys wait
                // Setup cycle plus timer 0..N-2 keeps the strobe low exactly N cycles
                if ((timer >= TW'(STROBE_NOM - 1)) ||
                    (!q_empty && timer >= TW'(STROBE_MIN - 1))) begin
                    next_timer = '0;
                    next_state = ST_GAP;
                end else begin
                    next_strobe = 1'b1;
                    next_timer = timer + 1'b1;
                end
            end
            ST_GAP: begin
                if (timer >= TW'(STROBE_GAP - 1)) begin
                    next_timer = '0;
                    next_state = ST_IDLE;
                end else begin
                    next_timer = timer + 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_timer = '0;
            end
        endcase
        if (!rep_sync && state == ST_IDLE) begin
            next_code_rep = (!q_empty) ? next_code_rep : 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            timer <= '0;
            code <= 7'h00;
            code_rep <= 1'b0;
            strobe <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            code <= next_code;
            code_rep <= next_code_rep;
            strobe <= next_strobe;
        end
    end

    // Output drivers, all active low and high out of reset; trailing edge of the
    // strobe rises while the code is still steady
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            code_n <= `IDLE_CODE_N;
            key_valid_pulse_n <= 1'b1;
            func_out_n <= '1;
            mod_out_n <= '1;
        end else begin
            code_n <= ~next_code;
            key_valid_pulse_n <= ~next_strobe;
            func_out_n <= ~func_sync;
            mod_out_n <= ~mod_sync;
        end
    end
endmodule

// file: verif/kbd_port_model.sv
`timescale 1ns/1ns
module kbd_port_model (
    input wire logic sys_clk, // Port sampling clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire kbd_pkg::key_code_t code_n, // Position code lines, active low
    input wire logic key_valid_pulse_n, // Strobe, low while active
    output kbd_pkg::key_code_t got_code, // Code taken at the strobe's rising edge
    output logic got_stb, // High for one cycle as each capture lands on got_code
    output logic [7:0] rom_addr // Character lookup address
);
    import kbd_pkg::*;
    logic prev_n;
    logic next_prev_n;
    logic next_got_stb;
    key_code_t next_got_code;

    // Take the code on the trailing edge only, so a code still settling is never latched
    always_comb begin
        next_prev_n = key_valid_pulse_n;
        next_got_stb = !prev_n && key_valid_pulse_n;
        next_got_code = next_got_stb ? ~code_n : got_code;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prev_n <= 1'b1;
            got_stb <= 1'b0;
            got_code <= 7'h00;
        end else begin
            prev_n <= next_prev_n;
            got_stb <= next_got_stb;
            got_code <= next_got_code;
        end
    end

    // The code is only an index; the character itself comes out of ROM
    assign rom_addr = {1'b0, got_code};
endmodule

// file: verif/keyboard_position_encoder_assertions.sv
`timescale 1ns/1ns
module keyboard_position_encoder_assertions #(
    parameter int STROBE_NOM = 50, // Strobe length, cycles
    parameter int STROBE_MIN = 10, // Shortest strobe, cycles
    parameter int FUNC_W = 8 // Number of function keys
) (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [FUNC_W-1:0] func_key_n, // Function keys in
    input wire logic [2:0] mod_key_n, // Modifier keys in
    input wire logic [6:0] code_n, // Position code out
    input wire logic key_valid_pulse_n, // Strobe out
    input wire logic [FUNC_W-1:0] func_out_n, // Function keys out
    input wire logic [2:0] mod_out_n // Modifier keys out
);
    import kbd_pkg::*;
    int low_cnt;
    int next_low_cnt;

    // Length of the current strobe, so the bound can be checked at its end
    always_comb next_low_cnt = key_valid_pulse_n ? 0 : low_cnt + 1;
    always_ff @(posedge sys_clk) low_cnt <= reset_n ? next_low_cnt : 0;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence strobe_start;
        $fell(key_valid_pulse_n);
    endsequence
    sequence strobe_end;
        $rose(key_valid_pulse_n);
    endsequence
    sequence quiet_gap;
        key_valid_pulse_n [*3];
    endsequence

    chk_strobe_len: assert property (strobe_end |-> low_cnt >= STROBE_MIN && low_cnt <= STROBE_NOM)
        else $error("strobe length out of range");
    chk_code_setup: assert property ($changed(code_n) |-> key_valid_pulse_n ##1 !key_valid_pulse_n)
        else $error("code change not followed by strobe");
    chk_code_stable: assert property (!key_valid_pulse_n |-> $stable(code_n))
        else $error("code moved under strobe");
    chk_strobe_gap: assert property (strobe_end |-> quiet_gap)
        else $error("strobes too close");
    chk_strobe_code: assert property (strobe_start |-> code_n != 7'h7F)
        else $error("strobe with idle code");
    chk_func_pass: assert property ($past(reset_n, 4) |-> func_out_n == $past(func_key_n, 3))
        else $error("function key output wrong");
    chk_mod_pass: assert property ($past(reset_n, 4) |-> mod_out_n == $past(mod_key_n, 3))
        else $error("modifier output wrong");
    chk_reset_idle: assert property ($rose(reset_n) |-> code_n == 7'h7F && key_valid_pulse_n
        && &func_out_n && &mod_out_n)
        else $error("outputs not idle after reset");
endmodule

bind keyboard_position_encoder keyboard_position_encoder_assertions #(
    .STROBE_NOM(STROBE_NOM), .STROBE_MIN(STROBE_MIN), .FUNC_W(FUNC_W)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .func_key_n(func_key_n), .mod_key_n(mod_key_n),
    .code_n(code_n), .key_valid_pulse_n(key_valid_pulse_n), .func_out_n(func_out_n),
    .mod_out_n(mod_out_n));

// file: verif/keyboard_position_encoder_tb.sv
`timescale 1ns/1ns
module keyboard_position_encoder_tb;
    import kbd_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    code_lines_t code_line_n = 13'h1FFF;
    logic repeat_hold = 1'b0;
    logic [7:0] func_key_n = 8'hFF;
    logic [2:0] mod_key_n = 3'h7;
    logic [6:0] code_n;
    logic key_valid_pulse_n;
    logic [7:0] func_out_n;
    logic [2:0] mod_out_n;
    key_code_t got_code;
    logic got_stb;
    logic [7:0] rom_addr;
    int err_count = 0;
    int samples_checked = 0;
    int caps = 0;
    key_code_t exp_q[$];
    key_code_t last_exp = 7'h00;
    // Line pair and position code, packed as {lower line, upper line, code}
    logic [15:0] key_map [78] = '{16'h360C, 16'h2803, 16'h2904, 16'h2A05, 16'h2B06, 16'h2C07,
        16'h2D08, 16'h3409, 16'h130A, 16'h350B, 16'h2702, 16'h140D, 16'h150E, 16'h160F, 16'h1710,
        16'h3812, 16'h3913, 16'h3A14, 16'h3B15, 16'h3C16, 16'h3D17, 16'h4518, 16'h4619, 16'h471A,
        16'h481B, 16'h491C, 16'h4A1D, 16'h1201, 16'h181F, 16'h4C20, 16'h4D21, 16'h5622, 16'h5723,
        16'h5824, 16'h5925, 16'h5A26, 16'h5B27, 16'h5C28, 16'h5D29, 16'h2439, 16'h1A2B, 16'h1B2C,
        16'h672D, 16'h1C2E, 16'h682F, 16'h6930, 16'h6A31, 16'h6B32, 16'h6C33, 16'h6D34, 16'h1D35,
        16'h7836, 16'h2338, 16'h192A, 16'h7A3A, 16'h7B3B, 16'h7C3C, 16'h7D3D, 16'h893E, 16'h8A3F,
        16'h8B40, 16'h8C41, 16'h8D42, 16'h9A43, 16'h9B44, 16'h9C45, 16'h2546, 16'h2647, 16'h9D48,
        16'hAB49, 16'hAD4A, 16'hBD4B, 16'hCD4C, 16'hAC4D, 16'hBC4E, 16'h7937, 16'h3711, 16'h4B1E};

    keyboard_position_encoder #(.STROBE_NOM(50), .STROBE_MIN(10), .STROBE_GAP(3),
        .REPEAT_PERIOD(200), .FUNC_W(8)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .code_line_n(code_line_n),
        .repeat_hold(repeat_hold), .func_key_n(func_key_n), .mod_key_n(mod_key_n),
        .code_n(code_n), .key_valid_pulse_n(key_valid_pulse_n), .func_out_n(func_out_n),
        .mod_out_n(mod_out_n));

    kbd_port_model port (
        .sys_clk(sys_clk), .reset_n(reset_n), .code_n(code_n),
        .key_valid_pulse_n(key_valid_pulse_n), .got_code(got_code), .got_stb(got_stb),
        .rom_addr(rom_addr));

    // 100 MHz clock
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check_code(input key_code_t exp, input key_code_t got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic check_val(input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hold a line pattern, then release all lines; at least one idle cycle follows
    task automatic drive(input code_lines_t pat, input int hold);
        @(posedge sys_clk);
        code_line_n <= pat;
        repeat (hold) @(posedge sys_clk);
        code_line_n <= 13'h1FFF;
    endtask

    task automatic press(input int idx);
        logic [15:0] e;
        code_lines_t pat;
        e = key_map[idx];
        pat = 13'h1FFF;
        pat[e[15:12] - 4'h1] = 1'b0;
        pat[e[11:8] - 4'h1] = 1'b0;
        exp_q.push_back(e[6:0]);
        drive(pat, 3 + $urandom % 4);
    endtask

    // Bounded wait for the port to have taken n codes in all
    task automatic wait_caps(input int n, input int limit);
        int i;
        for (i = 0; i < limit && caps < n; i++) @(posedge sys_clk);
        if (caps < n) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, n, caps);
            end_sim();
        end
    endtask

    // Each code the port takes is matched against the model queue; repeats reuse the last
    always @(posedge sys_clk) begin
        if (got_stb === 1'b1) begin
            caps++;
            if (exp_q.size() > 0)
                last_exp = exp_q.pop_front();
            check_code(last_exp, got_code);
            check_val({8'h00, 1'b0, last_exp}, {8'h00, rom_addr});
        end
    end

    initial begin
        int i;
        int n;
        int s;
        key_code_t prev;
        n = $urandom(32'hC3E3EABC);
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check_code(7'h7F, code_n);
        check_val(16'h0FFF, {4'h0, key_valid_pulse_n, func_out_n, mod_out_n});
        $display("test reset done");
        // Every key position once, in a shuffled order
        s = $urandom % 78;
        for (i = 0; i < 78; i++) begin
            n = caps;
            press((i * 37 + s) % 78);
            wait_caps(n + 1, 400);
            repeat ($urandom % 8) @(posedge sys_clk);
        end
        $display("test map done");
        // Overlapping presses must come out in press order
        n = caps;
        for (i = 0; i < 3; i++) press($urandom % 78);
        wait_caps(n + 3, 1000);
        $display("test rollover done");
        // Patterns that are not a pair give nothing, and the last code stays
        prev = code_n;
        n = caps;
        drive(13'h1FFE, 4);
        drive(13'h1FF8, 4);
        drive(13'h0000, 4);
        repeat (300) @(posedge sys_clk);
        check_val(16'(n), 16'(caps));
        check_code(prev, code_n);
        $display("test invalid done");
        // A pair on line 1 or 2 repeats while held; a pair on lines 3 and up never does
        for (i = 0; i < 2; i++) begin
            n = caps;
            repeat_hold <= 1'b1;
            press(i == 0 ? 27 : 0);
            repeat (700) @(posedge sys_clk);
            repeat_hold <= 1'b0;
            repeat (300) @(posedge sys_clk);
            check_val(16'h0001, 16'(i == 0 ? (caps - n >= 2) : (caps - n == 1)));
        end
        $display("test repeat done");
        // Function and modifier keys pass straight out
        for (i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            func_key_n <= 8'($urandom);
            mod_key_n <= 3'($urandom);
            repeat (4) @(posedge sys_clk);
            #1;
            check_val({5'h0, func_key_n, mod_key_n}, {5'h0, func_out_n, mod_out_n});
        end
        $display("test bypass done");
        end_sim();
    end
endmodule
